/* File: design/analog_die_interrupt_collector.v */
`include "irq_collector_map.vh"
`default_nettype none

module analog_die_interrupt_collector #(
    parameter AW = `IRQC_ADDR_W,
    parameter DW = `IRQC_DATA_W
) (
    // Clock and reset
    input  wire          CLK,
    input  wire          RST_N,
    // Die-to-die register access
    input  wire [AW-1:0] ADDR,
    input  wire          RD_EN,
    input  wire          WR_EN,
    input  wire [DW-1:0] WDATA,
    output reg  [DW-1:0] RDATA,
    output reg           RD_VALID,
    // Supply and thermal sources
    input  wire          SUPPLY_LOW_PENDING,
    input  wire          CRANK_WAKE_PENDING,
    input  wire          DIE_HOT_PENDING,
    input  wire          BUS_DRIVER_OVERHEAT_PENDING,
    // Timer sources
    input  wire          TIMER_CHANNEL_ZERO_PENDING,
    input  wire          TIMER_CHANNEL_ONE_PENDING,
    input  wire          TIMER_CHANNEL_TWO_PENDING,
    input  wire          TIMER_CHANNEL_THREE_PENDING,
    input  wire          TIMER_WRAP_PENDING,
    // Serial port sources
    input  wire          SCI_FAULT_PENDING,
    input  wire          SCI_TRANSMIT_PENDING,
    input  wire          SCI_RECEIVE_PENDING,
    // Measurement, lifetime and calibration sources
    input  wire          CURRENT_DONE_PENDING,
    input  wire          VOLTAGE_DONE_PENDING,
    input  wire          LIFETIME_COUNTER_EVENT,
    input  wire          LIFETIME_COUNTER_IRQ_EN,
    input  wire          TEMPERATURE_DRIFT_REQUEST,
    // Interrupt toward the controller
    output reg           DIE_LINK_INTERRUPT_LINE
);

    // ------------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------------
    reg rst_meta_r;
    reg rst_sync_r;

    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    wire rst_n = rst_sync_r;

    // ------------------------------------------------------------------------
    // Source gathering
    // ------------------------------------------------------------------------
    // Sources are levels owned by their units; this block never holds them,
    // so a unit clearing its flag clears the mirror one cycle later.
    wire [DW-1:0]             upper_nxt;
    wire [`IRQC_LOWER_W-1:0]  lower_nxt;

    assign upper_nxt[`IRQC_BIT_SUPPLY_LOW] = SUPPLY_LOW_PENDING
                                           | CRANK_WAKE_PENDING;
    assign upper_nxt[`IRQC_BIT_DIE_HOT]    = DIE_HOT_PENDING;
    assign upper_nxt[`IRQC_BIT_BUS_HOT]    = BUS_DRIVER_OVERHEAT_PENDING;
    assign upper_nxt[`IRQC_BIT_TCH0]       = TIMER_CHANNEL_ZERO_PENDING;
    assign upper_nxt[`IRQC_BIT_TCH1]       = TIMER_CHANNEL_ONE_PENDING;
    assign upper_nxt[`IRQC_BIT_TCH2]       = TIMER_CHANNEL_TWO_PENDING;
    assign upper_nxt[`IRQC_BIT_TCH3]       = TIMER_CHANNEL_THREE_PENDING;
    assign upper_nxt[`IRQC_BIT_TWRAP]      = TIMER_WRAP_PENDING;

    assign lower_nxt[`IRQC_BIT_SCI_FAULT]  = SCI_FAULT_PENDING;
    assign lower_nxt[`IRQC_BIT_SCI_TX]     = SCI_TRANSMIT_PENDING;
    assign lower_nxt[`IRQC_BIT_SCI_RX]     = SCI_RECEIVE_PENDING;
    assign lower_nxt[`IRQC_BIT_MEAS_DONE]  = CURRENT_DONE_PENDING
                                           | VOLTAGE_DONE_PENDING;
    // An overflow with the unit's enable off never reaches the controller
    assign lower_nxt[`IRQC_BIT_LIFETIME]   = LIFETIME_COUNTER_EVENT
                                           & LIFETIME_COUNTER_IRQ_EN;
    assign lower_nxt[`IRQC_BIT_TEMP_DRIFT] = TEMPERATURE_DRIFT_REQUEST;

    // ------------------------------------------------------------------------
    // Mirror and disable registers
    // ------------------------------------------------------------------------
    reg [DW-1:0]             pending_flags_upper_r;
    reg [`IRQC_LOWER_W-1:0]  pending_flags_lower_r;
    reg [DW-1:0]             source_enable_upper_r;
    reg [`IRQC_LOWER_W-1:0]  source_enable_lower_r;

    always @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            pending_flags_upper_r <= `IRQC_RST_BYTE;
            pending_flags_lower_r <= `IRQC_RST_LOWER;
        end else begin
            pending_flags_upper_r <= upper_nxt;
            pending_flags_lower_r <= lower_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------------
    // Both windows reach the same registers; the blocking/non-blocking split
    // only matters to the link, which stalls or not before reaching here.
    wire [AW-1:0] base_blocking;
    wire [AW-1:0] base_nonblock;
    wire          in_blocking;
    wire          in_nonblock;
    wire          in_window;
    wire [7:0]    offset;
    wire          ofs_known;

    assign base_blocking = `IRQC_BASE_BLOCKING;
    assign base_nonblock = `IRQC_BASE_NONBLOCK;
    assign in_blocking = (ADDR[AW-1:8] == base_blocking[AW-1:8]);
    assign in_nonblock = (ADDR[AW-1:8] == base_nonblock[AW-1:8]);
    assign in_window   = in_blocking | in_nonblock;
    assign offset      = ADDR[7:0];
    assign ofs_known   = (offset == `IRQC_OFS_PEND_UPPER)
                       | (offset == `IRQC_OFS_PEND_LOWER)
                       | (offset == `IRQC_OFS_PRIO_CODE)
                       | (offset == `IRQC_OFS_UNUSED)
                       | (offset == `IRQC_OFS_ENA_UPPER)
                       | (offset == `IRQC_OFS_ENA_LOWER);

    wire hit     = in_window & ofs_known;
    wire wr_hit  = hit & WR_EN;
    wire rd_hit  = hit & RD_EN & ~WR_EN;

    // ------------------------------------------------------------------------
    // Disable register writes
    // ------------------------------------------------------------------------
    always @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            source_enable_upper_r <= `IRQC_RST_BYTE;
            source_enable_lower_r <= `IRQC_RST_LOWER;
        end else if (wr_hit) begin
            case (offset)
                `IRQC_OFS_ENA_UPPER: begin
                    source_enable_upper_r <= WDATA;
                end
                `IRQC_OFS_ENA_LOWER: begin
                    source_enable_lower_r <= WDATA[`IRQC_LOWER_W-1:0];
                end
                default: begin
                    // Mirrors, vector and the unused byte ignore writes
                    source_enable_upper_r <= source_enable_upper_r;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Priority vector
    // ------------------------------------------------------------------------
    wire [`IRQC_SRC_N-1:0] prio_req;
    wire [`IRQC_CODE_W-1:0] prio_code;

    // Upper bits first, so supply low gets code 1 and calibration code 14
    assign prio_req = {pending_flags_lower_r, pending_flags_upper_r};

    irq_priority_pick #(
        .N  (`IRQC_SRC_N),
        .CW (`IRQC_CODE_W)
    ) u_pick (
        .req  (prio_req),
        .code (prio_code)
    );

    // ------------------------------------------------------------------------
    // Interrupt line
    // ------------------------------------------------------------------------
    // Gated from the unmasked mirror, not the vector: a disabled source still
    // shows in the vector so software can poll it.
    wire [`IRQC_SRC_N-1:0] allowed;
    wire [`IRQC_SRC_N-1:0] disable_all;

    assign disable_all = {source_enable_lower_r, source_enable_upper_r};

    genvar g;
    generate
        for (g = 0; g < `IRQC_SRC_N; g = g + 1) begin : g_gate
            assign allowed[g] = prio_req[g] & ~disable_all[g];
        end
    endgenerate

    always @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            DIE_LINK_INTERRUPT_LINE <= 1'b0;
        end else begin
            DIE_LINK_INTERRUPT_LINE <= |allowed;
        end
    end

    // ------------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------------
    // Reads only select data; no source state changes on a read.
    reg [DW-1:0] rd_mux;

    always @* begin
        rd_mux = `IRQC_RST_BYTE;
        case (offset)
            `IRQC_OFS_PEND_UPPER: begin
                rd_mux = pending_flags_upper_r;
            end
            `IRQC_OFS_PEND_LOWER: begin
                rd_mux = {2'b00, pending_flags_lower_r};
            end
            `IRQC_OFS_PRIO_CODE: begin
                rd_mux = {4'h0, prio_code};
            end
            `IRQC_OFS_ENA_UPPER: begin
                rd_mux = source_enable_upper_r;
            end
            `IRQC_OFS_ENA_LOWER: begin
                rd_mux = {2'b00, source_enable_lower_r};
            end
            default: begin
                rd_mux = `IRQC_RST_BYTE;
            end
        endcase
    end

    always @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            RDATA    <= `IRQC_RST_BYTE;
            RD_VALID <= 1'b0;
        end else begin
            RD_VALID <= rd_hit;
            if (rd_hit) begin
                RDATA <= rd_mux;
            end else begin
                RDATA <= `IRQC_RST_BYTE;
            end
        end
    end

endmodule // analog_die_interrupt_collector

`default_nettype wire

/* File: design/irq_priority_pick.v */
`include "irq_collector_map.vh"
`default_nettype none

// Returns index+1 of the lowest set request bit, or zero when none is set.
module irq_priority_pick #(
    parameter N  = `IRQC_SRC_N,
    parameter CW = `IRQC_CODE_W
) (
    // Requests, bit 0 is most urgent
    input  wire [N-1:0]  req,
    // Winning code
    output reg  [CW-1:0] code
);

    integer i;

    // Walk from least urgent down so the most urgent set bit is last to write
    always @* begin
        code = `IRQC_CODE_NONE;
        for (i = N - 1; i >= 0; i = i - 1) begin
            if (req[i]) begin
                code = i[CW-1:0] + {{(CW-1){1'b0}}, 1'b1};
            end
        end
    end

endmodule // irq_priority_pick

`default_nettype wire

/* File: shared/irq_collector_map.vh */
`ifndef IRQ_COLLECTOR_MAP_VH
`define IRQ_COLLECTOR_MAP_VH

// ----------------------------------------------------------------------------
// Address decode
// ----------------------------------------------------------------------------
`define IRQC_ADDR_W          16
`define IRQC_BASE_BLOCKING   16'h0200
`define IRQC_BASE_NONBLOCK   16'h0300

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define IRQC_OFS_PEND_UPPER  8'h08
`define IRQC_OFS_PEND_LOWER  8'h09
`define IRQC_OFS_PRIO_CODE   8'h0a
`define IRQC_OFS_UNUSED      8'h0b
`define IRQC_OFS_ENA_UPPER   8'h0c
`define IRQC_OFS_ENA_LOWER   8'h0d

// ----------------------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------------------
`define IRQC_DATA_W          8
`define IRQC_LOWER_W         6
`define IRQC_SRC_N           14
`define IRQC_CODE_W          4
`define IRQC_RST_BYTE        8'h00
`define IRQC_RST_LOWER       6'h00
`define IRQC_CODE_NONE       4'h0

// ----------------------------------------------------------------------------
// Upper field positions
// ----------------------------------------------------------------------------
`define IRQC_BIT_SUPPLY_LOW  0
`define IRQC_BIT_DIE_HOT     1
`define IRQC_BIT_BUS_HOT     2
`define IRQC_BIT_TCH0        3
`define IRQC_BIT_TCH1        4
`define IRQC_BIT_TCH2        5
`define IRQC_BIT_TCH3        6
`define IRQC_BIT_TWRAP       7

// ----------------------------------------------------------------------------
// Lower field positions
// ----------------------------------------------------------------------------
`define IRQC_BIT_SCI_FAULT   0
`define IRQC_BIT_SCI_TX      1
`define IRQC_BIT_SCI_RX      2
`define IRQC_BIT_MEAS_DONE   3
`define IRQC_BIT_LIFETIME    4
`define IRQC_BIT_TEMP_DRIFT  5

`endif

/* File: testbench/irq_collector_asserts.sv */
`default_nettype none
// --------------------------------------------------------
// Checker on the collector's link and source ports
// --------------------------------------------------------
module irq_collector_asserts (
    // Clock, reset and link
    input wire logic        CLK,
    input wire logic        RST_N,
    input wire logic [15:0] ADDR,
    input wire logic        RD_EN,
    input wire logic        WR_EN,
    input wire logic [7:0]  RDATA,
    input wire logic        RD_VALID,
    // Sources watched
    input wire logic        SUPPLY_LOW_PENDING,
    input wire logic        TEMPERATURE_DRIFT_REQUEST,
    input wire logic        LIFETIME_COUNTER_IRQ_EN
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       hit;
    logic       rd_req;
    logic [7:0] ofs_r;
    assign hit = (ADDR[15:8] == 8'h02 || ADDR[15:8] == 8'h03) && ADDR[7:0] >= 8'h08
                 && ADDR[7:0] <= 8'h0d;
    assign rd_req = RD_EN && !WR_EN && hit;
    // Offset of the request answered in the current cycle
    always_ff @(posedge CLK) ofs_r <= ADDR[7:0];
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    read_answer_a: assert property (rd_req |=> RD_VALID)
        else $error("mapped read got no answer");
    stray_answer_a: assert property (!rd_req |=> !RD_VALID)
        else $error("answer without a mapped read");
    vector_high_a: assert property (RD_VALID && ofs_r == 8'h0a |-> RDATA[7:4] == 4'h0)
        else $error("vector upper bits not zero");
    lower_high_a: assert property (RD_VALID && (ofs_r == 8'h09 || ofs_r == 8'h0d)
        |-> RDATA[7:6] == 2'b00) else $error("lower register bits 7..6 not zero");
    reserved_zero_a: assert property (RD_VALID && ofs_r == 8'h0b |-> RDATA == 8'h00)
        else $error("reserved offset not zero");
    supply_bit_a: assert property (RD_VALID && ofs_r == 8'h08 && $past(SUPPLY_LOW_PENDING, 2)
        && $past(SUPPLY_LOW_PENDING) |-> RDATA[0]) else $error("supply low bit missing");
    supply_code_a: assert property (RD_VALID && ofs_r == 8'h0a && $past(SUPPLY_LOW_PENDING, 2)
        && $past(SUPPLY_LOW_PENDING) |-> RDATA == 8'h01) else $error("supply low not top code");
    drift_bit_a: assert property (RD_VALID && ofs_r == 8'h09
        && $past(TEMPERATURE_DRIFT_REQUEST, 2) && $past(TEMPERATURE_DRIFT_REQUEST) |-> RDATA[5])
        else $error("calibration bit missing");
    lifetime_gate_a: assert property (RD_VALID && ofs_r == 8'h09
        && !$past(LIFETIME_COUNTER_IRQ_EN, 2) && !$past(LIFETIME_COUNTER_IRQ_EN) |-> !RDATA[4])
        else $error("lifetime bit set while unit disabled");
endmodule // irq_collector_asserts

bind analog_die_interrupt_collector irq_collector_asserts chk (
    .CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .RD_EN(RD_EN), .WR_EN(WR_EN), .RDATA(RDATA),
    .RD_VALID(RD_VALID), .SUPPLY_LOW_PENDING(SUPPLY_LOW_PENDING),
    .TEMPERATURE_DRIFT_REQUEST(TEMPERATURE_DRIFT_REQUEST),
    .LIFETIME_COUNTER_IRQ_EN(LIFETIME_COUNTER_IRQ_EN)
);
`default_nettype wire

/* File: testbench/link_host.sv */
`default_nettype none
// --------------------------------------------------------
// Controller side of the register link
// --------------------------------------------------------
module link_host #(
    parameter int SETTLE = 4
) (
    // Link
    input  wire logic        CLK,
    output logic      [15:0] ADDR,
    output logic             RD_EN,
    output logic             WR_EN,
    output logic      [7:0]  WDATA
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] exp_q[$];
    initial begin
        ADDR = 16'hffff;
        RD_EN = 1'b0;
        WR_EN = 1'b0;
        WDATA = 8'h00;
    end
    // Released address and data lines show the inverse so a stale value never passes; both enables drop to zero
    task automatic req(input logic [15:0] a, input logic rd, input logic wr, input logic [7:0] d);
        @(negedge CLK);
        ADDR <= a;
        RD_EN <= rd;
        WR_EN <= wr;
        WDATA <= d;
        @(negedge CLK);
        ADDR <= ~a;
        RD_EN <= 1'b0;
        WR_EN <= 1'b0;
        WDATA <= ~d;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        req(a, 1'b1, 1'b0, 8'h00);
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        req(a, 1'b0, 1'b1, d);
    endtask
    // Results are read only after the source chain has settled
    task automatic settle();
        repeat (SETTLE) @(negedge CLK);
    endtask
endmodule // link_host
`default_nettype wire

/* File: testbench/testbench.sv */
`default_nettype none
// --------------------------------------------------------
// Self-checking bench for the interrupt collector
// --------------------------------------------------------
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rst_n, rd_en, wr_en, rd_valid, irq_line, cw, vd, lt_en;
    logic [15:0] addr;
    logic [7:0]  wdata, rdata, msk_hi, msk_lo;
    logic [13:0] src;
    int          num_errors = 0;
    int          checked = 0;

    link_host host (.CLK(clk), .ADDR(addr), .RD_EN(rd_en), .WR_EN(wr_en), .WDATA(wdata));
    analog_die_interrupt_collector dut (
        .CLK(clk), .RST_N(rst_n), .ADDR(addr), .RD_EN(rd_en), .WR_EN(wr_en), .WDATA(wdata),
        .RDATA(rdata), .RD_VALID(rd_valid), .SUPPLY_LOW_PENDING(src[0]),
        .CRANK_WAKE_PENDING(cw), .DIE_HOT_PENDING(src[1]), .BUS_DRIVER_OVERHEAT_PENDING(src[2]),
        .TIMER_CHANNEL_ZERO_PENDING(src[3]), .TIMER_CHANNEL_ONE_PENDING(src[4]),
        .TIMER_CHANNEL_TWO_PENDING(src[5]), .TIMER_CHANNEL_THREE_PENDING(src[6]),
        .TIMER_WRAP_PENDING(src[7]), .SCI_FAULT_PENDING(src[8]), .SCI_TRANSMIT_PENDING(src[9]),
        .SCI_RECEIVE_PENDING(src[10]), .CURRENT_DONE_PENDING(src[11]), .VOLTAGE_DONE_PENDING(vd),
        .LIFETIME_COUNTER_EVENT(src[12]), .LIFETIME_COUNTER_IRQ_EN(lt_en),
        .TEMPERATURE_DRIFT_REQUEST(src[13]), .DIE_LINK_INTERRUPT_LINE(irq_line)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("checked=%0d num_errors=%0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // An answer with no note pending is compared against unknown and so fails
    always @(negedge clk) begin
        if (rd_valid === 1'b1)
            check(rdata, host.exp_q.size() != 0 ? host.exp_q.pop_front() : 8'hxx);
    end

    function automatic logic [15:0] at(input logic [7:0] o);
        at = ($urandom % 2) ? {8'h03, o} : {8'h02, o};
    endfunction

    function automatic logic [13:0] eff();
        eff = src;
        eff[0] = src[0] | cw;
        eff[11] = src[11] | vd;
        eff[12] = src[12] & lt_en;
    endfunction

    task automatic check_all();
        logic [13:0] e;
        logic [3:0]  v;
        host.settle();
        e = eff();
        v = 4'h0;
        for (int i = 13; i >= 0; i--) begin
            if (e[i])
                v = 4'(i + 1);
        end
        host.rd(at(8'h08), e[7:0]);
        host.rd(at(8'h09), {2'b00, e[13:8]});
        host.rd(at(8'h0a), {4'h0, v});
        host.rd(at(8'h08), e[7:0]);
        check({7'h00, irq_line}, {7'h00, |(e & ~{msk_lo[5:0], msk_hi})});
    endtask

    task automatic set_masks(input logic [7:0] hi, input logic [7:0] lo);
        msk_hi = hi;
        msk_lo = lo & 8'h3f;
        host.wr(at(8'h0c), hi);
        host.wr(at(8'h0d), lo);
    endtask

    initial begin
        rst_n = 1'b0;
        {cw, vd, lt_en} = 3'b001;
        src = 14'h0000;
        void'($urandom(8652));
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        host.rd(at(8'h0c), 8'h00);
        host.rd(at(8'h0d), 8'h00);
        host.wr(at(8'h0b), 8'hff);
        host.wr(at(8'h08), 8'hff);
        host.rd(16'h020b, 8'h00);
        host.rd(16'h0308, 8'h00);
        host.req(16'h0207, 1'b1, 1'b0, 8'h00);
        host.req(16'h030e, 1'b1, 1'b0, 8'h00);
        host.req(16'h0408, 1'b1, 1'b0, 8'h00);
        host.req(at(8'h0c), 1'b1, 1'b1, 8'h5a);
        host.rd(at(8'h0c), 8'h5a);
        host.wr(16'h040c, 8'hff);
        host.rd(at(8'h0c), 8'h5a);
        $display("test reset_map done");
        for (int k = 0; k < 4; k++) begin
            set_masks(8'($urandom), 8'($urandom));
            host.rd(at(8'h0c), msk_hi);
            host.rd(at(8'h0d), msk_lo);
        end
        set_masks(8'h00, 8'h00);
        $display("test masks done");
        for (int i = 0; i < 14; i++) begin
            src = 14'(1) << i;
            check_all();
        end
        for (int j = 0; j < 3; j++) begin
            src = (j == 2) ? 14'h1000 : 14'h0000;
            {cw, vd, lt_en} = (3'b100 >> j) & 3'b110;
            check_all();
        end
        $display("test single_sources done");
        for (int k = 0; k < 24; k++) begin
            src = 14'($urandom);
            {cw, vd, lt_en} = 3'($urandom);
            set_masks(8'($urandom), 8'($urandom));
            check_all();
        end
        $display("test random_mix done");
        repeat (4) @(negedge clk);
        check(8'(host.exp_q.size()), 8'h00);
        end_of_test();
    end

    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        end_of_test();
    end
endmodule // testbench
`default_nettype wire
